// File: rtl/bstap_defs.svh
/*
 * Constants of the boundary-scan test port: lengths, field widths,
 * instruction codes and fixed values.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef BSTAP_DEFS_SVH
`define BSTAP_DEFS_SVH

// Instruction register
`define BSTAP_IR_LEN 10
`define BSTAP_IR_CAPTURE 10'h001
// Instruction codes, unlisted codes select bypass
`define BSTAP_OP_EXTEST 10'h000
`define BSTAP_OP_SAMPLE 10'h005
`define BSTAP_OP_IDCODE 10'h006
`define BSTAP_OP_USERCODE 10'h007
`define BSTAP_OP_CFG_START 10'h002
`define BSTAP_OP_CFG_DATA 10'h003
`define BSTAP_OP_BYPASS 10'h3ff

// Boundary chain lengths of the four density variants
`define BSTAP_BSR_LEN_A 438
`define BSTAP_BSR_LEN_B 690
`define BSTAP_BSR_LEN_C 798
`define BSTAP_BSR_LEN_D 1050
`define BSTAP_BSR_LEN `BSTAP_BSR_LEN_A

// Signature and identification layout
`define BSTAP_WORD_LEN 32
`define BSTAP_USER_BITS 7
`define BSTAP_USER_FIXED_BITS 25
`define BSTAP_ID_VER_BITS 4
`define BSTAP_ID_PART_BITS 16
`define BSTAP_ID_MFG_BITS 11
// Arbitrary neutral identity values
`define BSTAP_ID_VER 4'h3
`define BSTAP_ID_PART 16'h0abc
`define BSTAP_ID_MFG 11'h555
`define BSTAP_USER_FIXED 25'h0012345

// Configuration word buffer depth
`define BSTAP_FIFO_DEPTH 2

`endif

// File: rtl/bstap_pkg.sv
/*
 * Types of the boundary-scan test port.
 * Assumes bstap_defs.svh is on the include path.
 */
package bstap_pkg;
`include "bstap_defs.svh"

    // Port controller states
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha,
        ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc,
        ST_PAUSE_IR = 4'hd,
        ST_EXIT2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } bstap_state_t;

    // Data register chosen by the current instruction
    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h0,
        SEL_IDCODE = 3'h1,
        SEL_USER = 3'h2,
        SEL_SAMPLE = 3'h3,
        SEL_EXTEST = 3'h4,
        SEL_CFG_DATA = 3'h5
    } bstap_sel_t;

    // Test port pins as seen at the device
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstap_pins_t;

    // One configuration word with its valid flag
    typedef struct packed {
        logic valid;
        logic [`BSTAP_WORD_LEN-1:0] data;
    } bstap_cfg_t;

endpackage

// File: rtl/bstap_top.sv
/*
 * Boundary-scan test access port: controller, instruction register,
 * bypass, signature, identification and boundary chain, plus the
 * configuration loading instructions with a two-entry word buffer.
 * Assumes the test pins arrive asynchronously and are oversampled by
 * clk, several clk cycles per test clock phase; the tms wire is
 * pulled up by the bench, and configuration logic runs on clk.
 */
// Operation
// RULE1: Port follows the 1990 boundary-scan standard.
// RULE2: No boundary testing while configuration runs.
// RULE3: Sample captures pins, preloads pattern harmlessly.
// RULE4: Extest drives pins from chain, captures inputs.
// RULE5: Bypass puts one bit between data pins.
// RULE6: Usercode shifts out user signature register.
// RULE7: Idcode shifts out identification register.
// RULE8: Configuration instructions load device over port.
// RULE9: Instruction register is ten bits long.
// RULE10: Signature: 32 bits, 7 user, 25 fixed.
// RULE11: Chain length 438, 690, 798 or 1050.
// RULE12: Idcode: version, part, maker, one.
// RULE13: Undriven test inputs read as high.
// RULE14: Unassigned codes select the bypass bit.
// RULE15: Test reset loads the identification instruction.
`include "bstap_defs.svh"
module bstap_top #(
    parameter int BSR_LEN = `BSTAP_BSR_LEN
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire bstap_pkg::bstap_pins_t pins,
    input wire logic cfg_busy,
    input wire logic [`BSTAP_USER_BITS-1:0] user_bits,
    input wire logic [BSR_LEN-1:0] pin_in,
    input wire logic [BSR_LEN-1:0] core_out,
    input wire logic cfg_ready,
    output logic tdo,
    output logic tdo_oe_n,
    output logic [BSR_LEN-1:0] pin_out,
    output logic cfg_start,
    output bstap_pkg::bstap_cfg_t cfg_word
);
    import bstap_pkg::*;

    // The test clock is never used as a clock here: clk samples it and
    // its edges become enables. This trades a faster system clock (at
    // least eight clk cycles per tck period) for one clock domain and no
    // crossing logic between the port and the configuration side.
    // Lengths of the instruction and word shift paths
    localparam int IRL = `BSTAP_IR_LEN;
    localparam int WL = `BSTAP_WORD_LEN;

    // Synchronisers reset high: a floating pin reads as one [RULE13]
    bstap_pins_t s1_q, s1_d, s2_q, s2_d;
    logic tck_old_q, tck_old_d;

    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        tck_old_d = s2_q.tck;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q <= 3'h7; // [RULE13]
            s2_q <= 3'h7; // [RULE13]
            tck_old_q <= 1'h1;
        end else if (ce) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            tck_old_q <= tck_old_d;
        end
    end

    // Edges of the test clock, seen only past the second stage
    logic tck_rise, tck_fall;
    assign tck_rise = s2_q.tck & ~tck_old_q;
    assign tck_fall = ~s2_q.tck & tck_old_q;

    // Busy blocks only the two instructions that touch the pins; the
    // identification paths stay usable during configuration, so a host
    // can still find the device in the chain.
    // Instruction decode; unknown codes fall to bypass
    function automatic bstap_sel_t decode(input logic [IRL-1:0] op,
                                          input logic busy);
        bstap_sel_t s;
        unique case (op)
            `BSTAP_OP_EXTEST: s = busy ? SEL_BYPASS : SEL_EXTEST; // [RULE2]
            `BSTAP_OP_SAMPLE: s = busy ? SEL_BYPASS : SEL_SAMPLE; // [RULE2]
            `BSTAP_OP_IDCODE: s = SEL_IDCODE;
            `BSTAP_OP_USERCODE: s = SEL_USER;
            `BSTAP_OP_CFG_DATA: s = SEL_CFG_DATA; // [RULE8]
            default: s = SEL_BYPASS; // [RULE5] [RULE14]
        endcase
        return s;
    endfunction

    // The controller registers move only on a detected tck edge (start_q drops the next clk), so
    // ce low freezes the whole port, and a still test clock freezes these registers.
    // Port controller and its shift registers
    bstap_state_t st_q, st_d;
    logic [IRL-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic byp_q, byp_d;
    logic [WL-1:0] w_sh_q, w_sh_d;
    logic [BSR_LEN-1:0] bsr_sh_q, bsr_sh_d, upd_q, upd_d;
    logic tdo_q, tdo_d, oe_n_q, oe_n_d;
    logic start_q, start_d, push;
    bstap_sel_t sel;
    logic [WL-1:0] id_word, user_word;
    logic fifo_full;

    // Identification and signature words [RULE10] [RULE12]
    assign id_word = {`BSTAP_ID_VER, `BSTAP_ID_PART, `BSTAP_ID_MFG, 1'b1};
    assign user_word = {`BSTAP_USER_FIXED, user_bits};
    assign sel = decode(ir_q, cfg_busy);

    always_comb begin
        st_d = st_q;
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        byp_d = byp_q;
        w_sh_d = w_sh_q;
        bsr_sh_d = bsr_sh_q;
        upd_d = upd_q;
        tdo_d = tdo_q;
        oe_n_d = oe_n_q;
        start_d = 1'b0;
        push = 1'b0;
        if (tck_rise) begin
            // State moves and capture or shift on the rising edge [RULE1]
            unique case (st_q)
                ST_RESET: st_d = s2_q.tms ? ST_RESET : ST_IDLE;
                ST_IDLE: st_d = s2_q.tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: st_d = s2_q.tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: st_d = s2_q.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: st_d = s2_q.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: st_d = s2_q.tms ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: st_d = s2_q.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: st_d = s2_q.tms ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR: st_d = s2_q.tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: st_d = s2_q.tms ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: st_d = s2_q.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: st_d = s2_q.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: st_d = s2_q.tms ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: st_d = s2_q.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: st_d = s2_q.tms ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR: st_d = s2_q.tms ? ST_SEL_DR : ST_IDLE;
            endcase
            if (st_q == ST_CAP_IR) begin
                ir_sh_d = `BSTAP_IR_CAPTURE;
            end
            if (st_q == ST_SHIFT_IR) begin
                ir_sh_d = {s2_q.tdi, ir_sh_q[IRL-1:1]}; // [RULE9]
            end
            if (st_q == ST_CAP_DR) begin
                byp_d = 1'b0;
                unique case (sel)
                    SEL_IDCODE: w_sh_d = id_word; // [RULE7]
                    SEL_USER: w_sh_d = user_word; // [RULE6]
                    // Host polls the low bit before sending a word
                    SEL_CFG_DATA: w_sh_d = {{(WL-1){1'b0}}, fifo_full};
                    SEL_SAMPLE, SEL_EXTEST: bsr_sh_d = pin_in; // [RULE3] [RULE4]
                    default: byp_d = 1'b0;
                endcase
            end
            if (st_q == ST_SHIFT_DR) begin
                unique case (sel)
                    SEL_IDCODE, SEL_USER, SEL_CFG_DATA:
                        w_sh_d = {s2_q.tdi, w_sh_q[WL-1:1]};
                    SEL_SAMPLE, SEL_EXTEST:
                        bsr_sh_d = {s2_q.tdi, bsr_sh_q[BSR_LEN-1:1]}; // [RULE11]
                    default: byp_d = s2_q.tdi; // [RULE5]
                endcase
            end
        end
        if (tck_fall) begin
            // Updating on the fall gives the shift registers half a test
            // clock to settle before the update latch or tdo takes them.
            // Output and update act on the falling edge
            oe_n_d = !(st_q == ST_SHIFT_IR || st_q == ST_SHIFT_DR);
            if (st_q == ST_SHIFT_IR) begin
                tdo_d = ir_sh_q[0];
            end else if (st_q == ST_SHIFT_DR) begin
                unique case (sel)
                    SEL_IDCODE, SEL_USER, SEL_CFG_DATA: tdo_d = w_sh_q[0];
                    SEL_SAMPLE, SEL_EXTEST: tdo_d = bsr_sh_q[0];
                    default: tdo_d = byp_q; // [RULE5]
                endcase
            end
            if (st_q == ST_RESET) begin
                ir_d = `BSTAP_OP_IDCODE; // [RULE15]
            end
            if (st_q == ST_UPD_IR) begin
                ir_d = ir_sh_q;
                start_d = (ir_sh_q == `BSTAP_OP_CFG_START); // [RULE8]
            end
            if (st_q == ST_UPD_DR) begin
                if (sel == SEL_SAMPLE || sel == SEL_EXTEST) begin
                    upd_d = bsr_sh_q; // [RULE3]
                end
                // A word sent while full is ignored; host must poll
                push = (sel == SEL_CFG_DATA) && !fifo_full; // [RULE8]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= ST_RESET;
            ir_sh_q <= `BSTAP_IR_CAPTURE;
            ir_q <= `BSTAP_OP_IDCODE; // [RULE15]
            byp_q <= 1'b0;
            w_sh_q <= '0;
            bsr_sh_q <= '0;
            upd_q <= '0;
            tdo_q <= 1'b0;
            oe_n_q <= 1'b1;
            start_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
            byp_q <= byp_d;
            w_sh_q <= w_sh_d;
            bsr_sh_q <= bsr_sh_d;
            upd_q <= upd_d;
            tdo_q <= tdo_d;
            oe_n_q <= oe_n_d;
            start_q <= start_d;
        end
    end

    // Pin outputs are registered like every other output, so a change of
    // instruction reaches the pins one clk after it takes effect.
    // Boundary cells: pins follow the chain only under extest
    logic [BSR_LEN-1:0] pin_d, pin_q;
    logic drive_chain;
    // Never drive test patterns while configuration runs [RULE2]
    assign drive_chain = (sel == SEL_EXTEST) && !cfg_busy;

    genvar gi;
    generate
        for (gi = 0; gi < BSR_LEN; gi++) begin : g_cell
            // Sample leaves core values on the pins [RULE3] [RULE4]
            assign pin_d[gi] = drive_chain ? upd_q[gi] : core_out[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_q <= '0;
        end else if (ce) begin
            pin_q <= pin_d;
        end
    end

    // Pop and push may meet in one cycle: the pop frees the head first,
    // so the new word lands in the head entry; the second entry is always empty then.
    // Fullness is judged before the pop, so a word arriving as a full
    // buffer pops is still dropped; the host's polling covers this.
    // Words leave in the order they arrived.
    // Two-entry word buffer; head entry drives the output directly
    bstap_cfg_t e0_q, e0_d, e1_q, e1_d;
    logic pop;
    assign fifo_full = e0_q.valid & e1_q.valid;
    assign pop = e0_q.valid & cfg_ready;

    always_comb begin
        e0_d = e0_q;
        e1_d = e1_q;
        if (pop) begin
            e0_d = e1_q;
            e1_d.valid = 1'b0;
        end
        if (push) begin
            // Shifted word lands in the first free slot [RULE8]
            if (!e0_d.valid) begin
                e0_d = {1'b1, w_sh_q};
            end else begin
                e1_d = {1'b1, w_sh_q};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            e0_q <= '0;
            e1_q <= '0;
        end else if (ce) begin
            e0_q <= e0_d;
            e1_q <= e1_d;
        end
    end

    // Outputs straight from their registers
    assign tdo = tdo_q;
    assign tdo_oe_n = oe_n_q;
    assign pin_out = pin_q;
    assign cfg_start = start_q;
    assign cfg_word = e0_q;

endmodule

// File: sim/bstap_props.sv
/* Port checker of the test port.
   Assumes one clk domain and a synchronous active-low reset. */
module bstap_props #(
    parameter int BSR_LEN = 438
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire bstap_pkg::bstap_pins_t pins,
    input wire logic cfg_busy,
    input wire logic [BSR_LEN-1:0] core_out,
    input wire logic cfg_ready,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    input wire logic [BSR_LEN-1:0] pin_out,
    input wire logic cfg_start,
    input wire bstap_pkg::bstap_cfg_t cfg_word
);
    import bstap_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Reset check must run while reset is low
    rst_outs_a: assert property (disable iff (1'b0) ce && !rstn |=>
        tdo_oe_n && !tdo && !cfg_start && !cfg_word.valid)
        else $error("outputs active after reset");
    // Output pins follow the core while configuration runs
    busy_pins_a: assert property ($past(cfg_busy) && $past(ce) &&
        $past(rstn) |-> pin_out == $past(core_out))
        else $error("pins not from core while busy");
    start_pulse_a: assert property (cfg_start |=> !cfg_start)
        else $error("start pulse too long");
    start_time_a: assert property (cfg_start |-> !pins.tck && tdo_oe_n)
        else $error("start outside update");
    word_hold_a: assert property (cfg_word.valid && !cfg_ready
        |=> $stable(cfg_word)) else $error("word lost in stall");
    word_rise_a: assert property ($rose(cfg_word.valid) |->
        !pins.tck && tdo_oe_n) else $error("word outside update");
    // Serial output moves only after a test clock fall
    tdo_quiet_a: assert property (pins.tck [*7] |-> $stable(tdo) &&
        $stable(tdo_oe_n)) else $error("tdo moved with tck high");
    freeze_all_a: assert property (!ce |=> $stable(tdo) &&
        $stable(pin_out) && $stable(cfg_word)) else $error("state moved");
endmodule
bind bstap_top bstap_props #(.BSR_LEN(BSR_LEN)) u_props (.clk, .rstn, .ce,
    .pins, .cfg_busy, .core_out, .cfg_ready, .tdo, .tdo_oe_n, .pin_out,
    .cfg_start, .cfg_word);

// File: sim/bstap_sink.sv
/* Configuration engine model that takes words from the port.
   Assumes the bench sets stall and reads the words queue. */
module bstap_sink (
    input wire logic clk,
    input wire logic rstn,
    input wire logic stall,
    input wire bstap_pkg::bstap_cfg_t cfg_word,
    output logic cfg_ready
);
    import bstap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words[$];
    // Ready moves only after an edge; a stall holds words back
    always @(posedge clk) begin
        if (!rstn) begin
            cfg_ready <= 1'b0;
        end else begin
            if (cfg_word.valid && cfg_ready) begin
                words.push_back(cfg_word.data);
            end
            cfg_ready <= !stall;
        end
    end
endmodule

// File: sim/tb_top.sv
/* Bench of the test port: plays the test controller on the pins.
   Assumes design, checker and sink model are compiled before it. */
`include "bstap_defs.svh"
module tb_top;
    import bstap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int L = 438;
    localparam logic [L-1:0] ID = L'({`BSTAP_ID_VER, `BSTAP_ID_PART,
        `BSTAP_ID_MFG, 1'b1});
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, busy = 1'b0, stall = 1'b0;
    logic tck = 1'b0, tms_v = 1'b1, tms_en = 1'b1, tdi = 1'b0;
    logic tdo, oe_n, start, ready;
    logic [6:0] ubits = 7'h5a;
    logic [L-1:0] pin_in, core_out, pin_out, dout;
    bstap_cfg_t word;
    int errors = 0, comparisons = 0, cycles = 0, starts = 0;
    tri1 tms_w;
    // Released tms floats to the pull-up level
    assign tms_w = tms_en ? tms_v : 1'bz;
    always #4 clk = ~clk;
    bstap_top #(.BSR_LEN(L)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
        .pins({tck, tms_w, tdi}), .cfg_busy(busy), .user_bits(ubits),
        .pin_in(pin_in), .core_out(core_out), .cfg_ready(ready),
        .tdo(tdo), .tdo_oe_n(oe_n), .pin_out(pin_out),
        .cfg_start(start), .cfg_word(word));
    bstap_sink u_sink (.clk(clk), .rstn(rstn), .stall(stall),
        .cfg_word(word), .cfg_ready(ready));
    // Hang guard and start pulse counter
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (start) starts <= starts + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            end_sim();
        end
    end
    task automatic chk(string what, logic [L-1:0] exp, logic [L-1:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // One 120 ns test clock; tdo read just before the rise
    task automatic tbit(logic m, logic d, output logic o);
        @(negedge clk);
        tms_v = m;
        tdi = d;
        #54 o = tdo;
        tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask
    // Idle to shift state, n bits LSB first, back to Idle
    task automatic shift(logic ir, int n, logic [L-1:0] din,
                         output logic [L-1:0] q);
        logic o;
        q = '0;
        tbit(1'b1, 1'b0, o);
        if (ir) tbit(1'b1, 1'b0, o);
        tbit(1'b0, 1'b0, o);
        tbit(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tbit(i == n - 1, din[i], o);
            q[i] = o;
        end
        tbit(1'b1, 1'b0, o);
        tbit(1'b0, 1'b0, o);
    endtask
    task automatic ir(logic [9:0] c);
        shift(1'b1, 10, L'(c), dout);
        chk("ir capture", L'(10'h001), dout);
    endtask
    task automatic t_id();
        logic o;
        tbit(1'b0, 1'b0, o);
        shift(1'b0, 32, '0, dout);
        chk("idcode", ID, dout);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
        ir(`BSTAP_OP_USERCODE);
        shift(1'b0, 32, '0, dout);
        chk("user", L'({`BSTAP_USER_FIXED, ubits}), dout);
    endtask
    // Listed and unlisted codes alike give a one-bit path
    task automatic t_bypass();
        logic [9:0] codes[3] = '{10'h3ff, 10'h155, 10'h004};
        foreach (codes[k]) begin
            ir(codes[k]);
            shift(1'b0, 8, L'(8'hb5), dout);
            chk("bypass", L'(8'h6a), dout);
        end
    endtask
    task automatic t_scan();
        pin_in = L'({55{8'h96}});
        core_out = L'({55{8'h3c}});
        ir(`BSTAP_OP_SAMPLE);
        shift(1'b0, L, ~pin_in, dout);
        chk("sample", pin_in, dout);
        chk("normal pins", core_out, pin_out);
        ir(`BSTAP_OP_EXTEST);
        chk("extest drive", ~pin_in, pin_out);
        pin_in = ~core_out;
        shift(1'b0, L, '0, dout);
        chk("extest capture", ~core_out, dout);
        busy = 1'b1;
        repeat (2) @(negedge clk);
        chk("busy pins", core_out, pin_out);
        shift(1'b0, 8, L'(8'hb5), dout);
        chk("busy bypass", L'(8'h6a), dout);
        busy = 1'b0;
    endtask
    // Stalled engine: two words fit, the third is dropped
    task automatic t_cfg();
        stall = 1'b1;
        ir(`BSTAP_OP_CFG_START);
        ir(`BSTAP_OP_CFG_DATA);
        for (int w = 0; w < 3; w++) begin
            shift(1'b0, 32, L'(32'hc0de0000 + w), dout);
            chk("full flag", L'(w == 2), dout);
        end
        stall = 1'b0;
        for (int i = 0; i < 20 && u_sink.words.size() < 2; i++) @(negedge clk);
        repeat (8) @(negedge clk);
        chk("words", L'(2), L'(u_sink.words.size()));
        chk("word0", L'(32'hc0de0000), L'(u_sink.words[0]));
        chk("word1", L'(32'hc0de0001), L'(u_sink.words[1]));
        chk("starts", L'(1), L'(starts));
    endtask
    // Floating tms reads high, so five clocks reset the port
    task automatic t_pull();
        logic o;
        tms_en = 1'b0;
        repeat (5) tbit(1'b0, 1'b0, o);
        tms_en = 1'b1;
        tbit(1'b0, 1'b0, o);
        shift(1'b0, 32, '0, dout);
        chk("id after reset", ID, dout);
    endtask
    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        pin_in = '0;
        core_out = '0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_id();
        t_bypass();
        t_scan();
        t_cfg();
        t_pull();
        end_sim();
    end
endmodule
